// ---- dv/lts_pin_partner.sv ----
/*
  Pin-side party of the selector: drives each shared pin while the
  selector has released it.
  Assumes one enable and one output per shared pin.
*/
module lts_pin_partner (
  // selector side
  input  wire logic [3:0] oe,
  input  wire logic [3:0] dOut,
  // outside levels
  input  wire logic [3:0] ext,
  output logic      [3:0] pinLevel
);
  timeunit 1ns;
  timeprecision 100ps;
  // wire level: the enabled party wins, no contention modelled
  assign pinLevel = (oe & dOut) | (~oe & ext);
endmodule

// ---- dv/testbench.sv ----
/*
  Self-checking bench of the pin function selector.
  Assumes the selector header and package are compiled first.
*/
`include "lts_defs.svh"
module testbench
  import lts_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 0, rst = 1, clrN = 1, mw = 0, asg = 1, p17 = 1, p19 = 0;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, lfsrV = 32'h0000_aa7c;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]  bresp, rresp;
  logic [3:0]  ext = 0, oe, dOut, lvl;
  logic        cFsa = 0, cSs = 0, cTx = 0, cCl = 0, cWake = 0, cPd = 0, cPu = 0, cRx = 0;
  lts_cfg_e    cfgM;
  logic        asgM, ps1, pll, febe, frw, lts, txSys, fsaSys, ssSys, rxO, rxOe, lwO, lwOe;
  logic [2:0]  chan;
  int          n_mismatch = 0, n_tests = 0;
  int          wid [8] = '{2, 1, 2, 1, 1, 9, 3, 3};
  int          regs [8] = '{0, 0, 1, 0, 0, 0, 0, 0};

  // 200 MHz clock
  always #2.5 clk = ~clk;

  lts_pin_select dut (
    .clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq), .chipClearN(clrN),
    .microPortSelect(mw), .assignerVsStrapSelect(asg), .pin17In(p17), .pin19In(p19),
    .frameSyncAIn(lvl[0]), .frameSyncAOut(dOut[0]), .frameSyncAOe(oe[0]),
    .pin7In(lvl[1]), .pin7Out(dOut[1]), .pin7Oe(oe[1]),
    .generalPinOneIn(lvl[2]), .generalPinOneOut(dOut[2]), .generalPinOneOe(oe[2]),
    .txSuperframeIn(lvl[3]), .txSuperframeOut(dOut[3]), .txSuperframeOe(oe[3]),
    .rxSuperframeOut(rxO), .rxSuperframeOe(rxOe), .lineWakeOut(lwO), .lineWakeOe(lwOe),
    .coreFrameSyncA(cFsa), .coreSecondStrobe(cSs), .coreTxSfMark(cTx), .coreCordlessMsgOk(cCl),
    .coreRxSfLevel(cRx), .coreWakeTone(cWake), .corePowerDown(cPd), .corePoweredUp(cPu),
    .configMode(cfgM), .assignerMode(asgM), .chanNumber(chan), .ps1Bit(ps1), .pll1Disable(pll),
    .febeReportEn(febe), .freeRunSyncWord(frw), .lineTestSelB(lts), .txSuperframeSys(txSys),
    .frameSyncASys(fsaSys), .secondStrobeSys(ssSys));

  lts_pin_partner pins (.oe(oe), .dOut(dOut), .ext(ext), .pinLevel(lvl));

  // random source for pins, registers and core levels
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  // one comparison, counted
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // bus write; model keeps only the implemented low bits
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1;
    wvalid  <= 1;
    bready  <= 1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid);
    bready <= 0;
    chk("bresp", er, bresp);
    if (er == 0 && a != `LTS_OFF_IRQ_STAT) regs[a[4:2]] = d & ((1 << wid[a[4:2]]) - 1);
  endtask

  // bus read against an expected word
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1;
    rready  <= 1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 0;
    end while (!rvalid);
    rready <= 0;
    chk("rresp", er, rresp);
    chk("rdata", exp, rdata);
  endtask

  // verdict and end of run
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // hang guard, above the long clear plus a few thousand cycles of tests
  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    close_out();
  end

  // main sequence
  initial begin
    logic [31:0] r;
    logic        m, a, h, l, na;
    repeat (6) @(posedge clk);
    rst <= 0;
    repeat (3) @(posedge clk);
    // defaults, unmapped and read-only places
    rd(`LTS_OFF_CTRL_TWO, regs[0], 0);
    rd(`LTS_OFF_CTRL_FIVE, regs[2], 0);
    rd(`LTS_OFF_IRQ_MASK, 0, 0);
    rd(8'h20, 0, 2);
    wr(`LTS_OFF_STATUS, 1, 2);
    // random pin straps and register settings
    for (int i = 0; i < 48; i++) begin
      lfsrV = lfsr(lfsrV);
      r = lfsrV;
      m = r[0] & r[1];
      a = r[2];
      h = r[3];
      l = r[4];
      na = !a | (h & !l);
      wr(`LTS_OFF_CTRL_ONE, (r >> 8) & 1, 0);
      wr(`LTS_OFF_CTRL_TWO, (r >> 11) & 3, 0);
      wr(`LTS_OFF_CTRL_FOUR, (r >> 13) & 1, 0);
      wr(`LTS_OFF_CTRL_FIVE, (r >> 9) & 3, 0);
      wr(`LTS_OFF_CTRL_SEVEN, (r >> 14) & 1, 0);
      rd(`LTS_OFF_CTRL_FIVE, regs[2], 0);
      @(posedge clk);
      mw   <= m;
      asg  <= a;
      p17  <= h;
      p19  <= l;
      ext  <= r[20:17];
      cFsa <= r[15];
      cSs  <= r[16];
      cTx  <= r[21];
      // straps sync in two edges; the pin levels their new directions expose need two more
      repeat (4) @(posedge clk);
      #1;
      chk("frw", na & r[11] & !r[12], frw);
      chk("txSys", na & !(r[11] | r[12] | r[14]) & r[20], txSys);
      chk("fsaSys", !(m ? r[8] : (a & (h | !l))) & r[17], fsaSys);
      chk("ssSys", m & !r[8] & r[18], ssSys);
      if (oe[3]) chk("txOut", !r[14] & r[21], dOut[3]);
      chk("fsaOe", m ? r[8] : (a & (h | !l)), oe[0]);
      chk("p7Oe", m ? r[8] : (a & h & !l), oe[1]);
      chk("gpOe", !m & na & !r[9], oe[2]);
      if (oe[2]) chk("gpOut", r[10], dOut[2]);
      if (oe[0]) chk("fsaOut", r[15], dOut[0]);
      if (oe[1]) chk("p7Out", r[16], dOut[1]);
      chk("rxOe", !m & na & r[13], rxOe);
      if (!m) begin
        chk("txOe", na & (r[12] | r[11] | r[14]), oe[3]);
        chk("asg", !a, asgM);
        chk("chan", a ? 0 : {h, l, r[18]}, chan);
        if (a) chk("cfg", {h, l}, cfgM);
        if (a & (h == l)) chk("ps1", r[19], ps1);
        if (a & !h & l) chk("pll", r[19], pll);
        if (!na) chk("febe", r[20], febe);
        if (a & !(h & !l)) chk("tsb", r[18], lts);
      end
    end
    // cordless pulse on the tx superframe pin
    @(posedge clk);
    mw  <= 0;
    asg <= 0;
    cTx <= 0;
    wr(`LTS_OFF_CTRL_SEVEN, 1, 0);
    wr(`LTS_OFF_CTRL_TWO, 0, 0);
    repeat (3) @(posedge clk);
    cCl <= 1;
    @(posedge clk);
    cCl <= 0;
    #1 chk("txPulse", 1, dOut[3]);
    chk("txOe", 1, oe[3]);
    @(posedge clk);
    #1 chk("txPulseEnd", 0, dOut[3]);
    rd(`LTS_OFF_IRQ_STAT, 2, 0);
    wr(`LTS_OFF_IRQ_STAT, 2, 0);
    // wake tone in power down, masked first
    @(posedge clk);
    cPd   <= 1;
    cWake <= 1;
    @(posedge clk);
    cWake <= 0;
    @(posedge clk);
    #1 chk("lwOe", 1, lwOe);
    chk("lwOut", 0, lwO);
    chk("irqMasked", 0, irq);
    wr(`LTS_OFF_IRQ_MASK, 1, 0);
    #1 chk("irq", 1, irq);
    @(posedge clk);
    cPu <= 1;
    cPd <= 0;
    @(posedge clk);
    cPu <= 0;
    repeat (2) @(posedge clk);
    #1 chk("lwOe", 0, lwOe);
    rd(`LTS_OFF_IRQ_STAT, 1, 0);
    wr(`LTS_OFF_IRQ_STAT, 1, 0);
    #1 chk("irqClr", 0, irq);
    // rx superframe start edge is stored once
    @(posedge clk);
    cRx <= 1;
    @(posedge clk);
    #1 chk("rxOut", 1, rxO);
    rd(`LTS_OFF_IRQ_STAT, 4, 0);
    cRx <= 0;
    wr(`LTS_OFF_IRQ_STAT, 4, 0);
    rd(`LTS_OFF_IRQ_STAT, 0, 0);
    // clear held low for 200 us
    wr(`LTS_OFF_CTRL_FIVE, 2, 0);
    @(posedge clk);
    clrN <= 0;
    repeat (40000) @(posedge clk);
    clrN <= 1;
    repeat (3) @(posedge clk);
    regs = '{0, 0, 1, 0, 0, 0, 0, 0};
    rd(`LTS_OFF_CTRL_FIVE, regs[2], 0);
    rd(`LTS_OFF_IRQ_MASK, 0, 0);
    close_out();
  end
endmodule

// ---- inc/lts_defs.svh ----
/*
  Register offsets, field positions and reset values of the line transceiver
  pin function selector.
  Assumes a 32-bit AXI4-Lite register bus with byte addresses.
*/
`ifndef LTS_DEFS_SVH
`define LTS_DEFS_SVH

// register byte offsets
`define LTS_OFF_CTRL_TWO   8'h00
`define LTS_OFF_CTRL_FOUR  8'h04
`define LTS_OFF_CTRL_FIVE  8'h08
`define LTS_OFF_CTRL_SEVEN 8'h0C
`define LTS_OFF_CTRL_ONE   8'h10
`define LTS_OFF_STATUS     8'h14
`define LTS_OFF_IRQ_STAT   8'h18
`define LTS_OFF_IRQ_MASK   8'h1C

// control field positions
`define LTS_BIT_SF_DIR     0
`define LTS_BIT_NT_MODE    1
`define LTS_BIT_RX_SF_EN   0
`define LTS_BIT_IO1_DIR    0
`define LTS_BIT_IO1_OUT    1
`define LTS_BIT_CORDLESS   0
`define LTS_BIT_CLK_MASTER 0

// interrupt bits
`define LTS_IRQ_W          3
`define LTS_IRQ_WAKE       0
`define LTS_IRQ_CORDLESS   1
`define LTS_IRQ_RX_SF      2

// reset values
`define LTS_RST_CTRL_TWO   2'h0
`define LTS_RST_CTRL_FIVE  2'h1
`define LTS_RST_IRQ_MASK   3'h0

// bus responses
`define LTS_RESP_OKAY      2'h0
`define LTS_RESP_SLVERR    2'h2

`endif

// ---- inc/lts_pkg.sv ----
/*
  Types of the line transceiver pin function selector.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package lts_pkg;
  // strap configuration, encoded as {strap_high_bit, strap_low_bit}
  typedef enum logic [1:0] {
    LTS_CFG_NTRR,
    LTS_CFG_LTRR,
    LTS_CFG_NTTE,
    LTS_CFG_NT1
  } lts_cfg_e;
endpackage

// ---- rtl/lts_pin_select.sv ----
/*
  Pin function and direction selector of a 2B1Q line transceiver, with its
  control registers on AXI4-Lite and one level interrupt.
  Assumes the transceiver core runs on clk and that all pins arrive unsynced.
*/
`include "lts_defs.svh"

module lts_pin_select
  import lts_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // interrupt
  output logic                   irq,
  // strap and select pins
  input  wire logic              chipClearN,
  input  wire logic              microPortSelect,
  input  wire logic              assignerVsStrapSelect,
  input  wire logic              pin17In,
  input  wire logic              pin19In,
  // frame sync a pin
  input  wire logic              frameSyncAIn,
  output logic                   frameSyncAOut,
  output logic                   frameSyncAOe,
  // pin 7
  input  wire logic              pin7In,
  output logic                   pin7Out,
  output logic                   pin7Oe,
  // general pin one
  input  wire logic              generalPinOneIn,
  output logic                   generalPinOneOut,
  output logic                   generalPinOneOe,
  // tx superframe pin
  input  wire logic              txSuperframeIn,
  output logic                   txSuperframeOut,
  output logic                   txSuperframeOe,
  // rx superframe pin
  output logic                   rxSuperframeOut,
  output logic                   rxSuperframeOe,
  // line wake pin, open drain
  output logic                   lineWakeOut,
  output logic                   lineWakeOe,
  // transceiver core, same clock
  input  wire logic              coreFrameSyncA,
  input  wire logic              coreSecondStrobe,
  input  wire logic              coreTxSfMark,
  input  wire logic              coreCordlessMsgOk,
  input  wire logic              coreRxSfLevel,
  input  wire logic              coreWakeTone,
  input  wire logic              corePowerDown,
  input  wire logic              corePoweredUp,
  // results to the core
  output lts_cfg_e               configMode,
  output logic                   assignerMode,
  output logic [2:0]             chanNumber,
  output logic                   ps1Bit,
  output logic                   pll1Disable,
  output logic                   febeReportEn,
  output logic                   freeRunSyncWord,
  output logic                   lineTestSelB,
  output logic                   txSuperframeSys,
  output logic                   frameSyncASys,
  output logic                   secondStrobeSys
);

  // synchronised pins
  logic [8:0] pinSync;
  wire        clearN   = pinSync[8];
  wire        mwPin    = pinSync[7];
  wire        moPin    = pinSync[6];
  wire        p17      = pinSync[5];
  wire        p19      = pinSync[4];
  wire        p7       = pinSync[3];
  wire        fsaPin   = pinSync[2];
  wire        gpPin    = pinSync[1];
  wire        p22      = pinSync[0];

  lts_sync2 #(.WIDTH(9)) u_sync (
    .clk     (clk),
    .rst     (rst),
    .asyncIn ({chipClearN, microPortSelect, assignerVsStrapSelect, pin17In, pin19In,
               pin7In, frameSyncAIn, generalPinOneIn, txSuperframeIn}),
    .syncOut (pinSync)
  );

  // control registers
  logic [1:0]           ctrlTwo_r;
  logic                 ctrlFour_r;
  logic [1:0]           ctrlFive_r;
  logic                 ctrlSeven_r;
  logic                 ctrlOne_r;
  logic [`LTS_IRQ_W-1:0] irqStat_r;
  logic [`LTS_IRQ_W-1:0] irqMask_r;
  logic                 wake_r;
  logic                 rxSfPrev_r;
  logic                 txSfOut_r;
  logic                 rxSfOut_r;

  // configuration decode
  // no added latency
  assign assignerMode = ~moPin;
  assign configMode   = lts_cfg_e'({p17, p19});
  wire   cfgNtte      = moPin & (configMode == LTS_CFG_NTTE);
  wire   cfgNt1       = moPin & (configMode == LTS_CFG_NT1);
  wire   cfgLtrr      = moPin & (configMode == LTS_CFG_LTRR);
  wire   cfgNtrr      = moPin & (configMode == LTS_CFG_NTRR);
  wire   nonAuto      = assignerMode | cfgNtte;
  wire   autoMode     = ~nonAuto;
  wire   sfDir        = ctrlTwo_r[`LTS_BIT_SF_DIR];
  wire   ntMode       = ctrlTwo_r[`LTS_BIT_NT_MODE];
  wire   io1IsIn      = ctrlFive_r[`LTS_BIT_IO1_DIR];

  assign chanNumber   = assignerMode ? {p17, p19, p7} : 3'h0;

  // general pin one and its alternate inputs
  // general purpose I/O
  assign generalPinOneOe  = ~mwPin & nonAuto & ~io1IsIn;
  assign generalPinOneOut = ctrlFive_r[`LTS_BIT_IO1_OUT];
  assign ps1Bit       = ~mwPin & (cfgNt1 | cfgNtrr) & gpPin;
  assign pll1Disable  = ~mwPin & cfgLtrr & gpPin;

  assign febeReportEn = ~mwPin & autoMode & p22;

  // tx superframe pin direction; cordless pulses need the pin driven
  // superframe direction
  assign txSuperframeOe  = nonAuto & (ntMode | sfDir | ctrlSeven_r);
  assign freeRunSyncWord = nonAuto & sfDir & ~ntMode;
  assign txSuperframeSys = (nonAuto & ~txSuperframeOe) ? p22 : 1'b0;
  assign txSuperframeOut = txSfOut_r;

  assign rxSuperframeOe  = ctrlFour_r & ~mwPin & nonAuto;
  assign rxSuperframeOut = rxSfOut_r;

  assign frameSyncAOe  = mwPin ? ctrlOne_r : (moPin & (p17 | ~p19));
  assign frameSyncAOut = coreFrameSyncA;
  assign frameSyncASys = frameSyncAOe ? 1'b0 : fsaPin;

  assign pin7Oe          = mwPin ? ctrlOne_r : (moPin & p17 & ~p19);
  assign pin7Out         = coreSecondStrobe;
  assign secondStrobeSys = (mwPin & ~pin7Oe) ? p7 : 1'b0;
  assign lineTestSelB    = (~mwPin & moPin & ~pin7Oe) ? p7 : 1'b0;

  // open drain wake, only ever pulls low
  assign lineWakeOut = 1'b0;
  assign lineWakeOe  = wake_r;

  // bus slave state
  logic              awHeld_r;
  logic              wHeld_r;
  logic [ADDR_W-1:0] awAddr_r;
  logic [31:0]       wData_r;
  logic              wStrb0_r;

  assign s_axi_awready = ~awHeld_r & ~s_axi_bvalid;
  assign s_axi_wready  = ~wHeld_r & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  wire   doWrite       = awHeld_r & wHeld_r & ~s_axi_bvalid;
  wire   wrEn          = doWrite & wStrb0_r;
  wire   arFire        = s_axi_arvalid & s_axi_arready;

  // write decode
  wire wrTwo    = wrEn & (awAddr_r == `LTS_OFF_CTRL_TWO);
  wire wrFour   = wrEn & (awAddr_r == `LTS_OFF_CTRL_FOUR);
  wire wrFive   = wrEn & (awAddr_r == `LTS_OFF_CTRL_FIVE);
  wire wrSeven  = wrEn & (awAddr_r == `LTS_OFF_CTRL_SEVEN);
  wire wrOne    = wrEn & (awAddr_r == `LTS_OFF_CTRL_ONE);
  wire wrStat   = wrEn & (awAddr_r == `LTS_OFF_IRQ_STAT);
  wire wrMask   = wrEn & (awAddr_r == `LTS_OFF_IRQ_MASK);
  wire wrMapped = (awAddr_r[7:0] <= `LTS_OFF_IRQ_MASK) & (awAddr_r[1:0] == 2'h0)
                  & (awAddr_r != `LTS_OFF_STATUS);

  // read decode; status shows the live pin configuration
  wire [31:0] statusWord = {23'h0, mwPin, wake_r, gpPin, chanNumber, moPin, p17, p19};
  wire [7:0]  rdAddr     = s_axi_araddr[7:0];
  wire        rdMapped   = (rdAddr <= `LTS_OFF_IRQ_MASK) & (rdAddr[1:0] == 2'h0);
  wire [31:0] rdMux =
    (rdAddr == `LTS_OFF_CTRL_TWO)   ? {30'h0, ctrlTwo_r}  :
    (rdAddr == `LTS_OFF_CTRL_FOUR)  ? {31'h0, ctrlFour_r} :
    (rdAddr == `LTS_OFF_CTRL_FIVE)  ? {30'h0, ctrlFive_r} :
    (rdAddr == `LTS_OFF_CTRL_SEVEN) ? {31'h0, ctrlSeven_r} :
    (rdAddr == `LTS_OFF_CTRL_ONE)   ? {31'h0, ctrlOne_r}  :
    (rdAddr == `LTS_OFF_STATUS)     ? statusWord          :
    (rdAddr == `LTS_OFF_IRQ_STAT)   ? {29'h0, irqStat_r}  :
    (rdAddr == `LTS_OFF_IRQ_MASK)   ? {29'h0, irqMask_r}  : 32'h0000_0000;

  // address and data may arrive in either order
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      awHeld_r <= 1'b0;
      wHeld_r  <= 1'b0;
      awAddr_r <= '0;
      wData_r  <= 32'h0000_0000;
      wStrb0_r <= 1'b0;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        awHeld_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
      end else if (doWrite) begin
        awHeld_r <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        wHeld_r  <= 1'b1;
        wData_r  <= s_axi_wdata;
        wStrb0_r <= s_axi_wstrb[0];
      end else if (doWrite) begin
        wHeld_r <= 1'b0;
      end
    end
  end

  // write response one cycle after both halves are held
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `LTS_RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wrMapped ? `LTS_RESP_OKAY : `LTS_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read data registered; unmapped reads give zero and an error
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `LTS_RESP_OKAY;
    end else if (arFire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rdMux;
      s_axi_rresp  <= rdMapped ? `LTS_RESP_OKAY : `LTS_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // control registers; the clear pin restores defaults like reset
  // chip clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrlTwo_r   <= `LTS_RST_CTRL_TWO;
      ctrlFour_r  <= 1'b0;
      ctrlFive_r  <= `LTS_RST_CTRL_FIVE;
      ctrlSeven_r <= 1'b0;
      ctrlOne_r   <= 1'b0;
      irqMask_r   <= `LTS_RST_IRQ_MASK;
    end else if (~clearN) begin
      ctrlTwo_r   <= `LTS_RST_CTRL_TWO;
      ctrlFour_r  <= 1'b0;
      ctrlFive_r  <= `LTS_RST_CTRL_FIVE;
      ctrlSeven_r <= 1'b0;
      ctrlOne_r   <= 1'b0;
      irqMask_r   <= `LTS_RST_IRQ_MASK;
    end else begin
      if (wrTwo)   ctrlTwo_r   <= wData_r[1:0];
      if (wrFour)  ctrlFour_r  <= wData_r[`LTS_BIT_RX_SF_EN];
      if (wrFive)  ctrlFive_r  <= wData_r[1:0];
      if (wrSeven) ctrlSeven_r <= wData_r[`LTS_BIT_CORDLESS];
      if (wrOne)   ctrlOne_r   <= wData_r[`LTS_BIT_CLK_MASTER];
      if (wrMask)  irqMask_r   <= wData_r[`LTS_IRQ_W-1:0];
    end
  end

  // events; a new event wins over a write-one clear
  // superframe start edge
  wire rxSfRise = coreRxSfLevel & ~rxSfPrev_r;
  wire cordlessPulse = ctrlSeven_r & coreCordlessMsgOk;
  wire wakeSet = coreWakeTone & corePowerDown & ~corePoweredUp;
  wire [`LTS_IRQ_W-1:0] irqEvt = {rxSfRise, cordlessPulse, wakeSet};
  wire [`LTS_IRQ_W-1:0] irqClr = wrStat ? wData_r[`LTS_IRQ_W-1:0] : '0;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irqStat_r  <= '0;
      rxSfPrev_r <= 1'b0;
    end else begin
      irqStat_r  <= clearN ? ((irqStat_r & ~irqClr) | irqEvt) : '0;
      rxSfPrev_r <= coreRxSfLevel;
    end
  end

  assign irq = |(irqStat_r & irqMask_r);

  // pin output flops
  // cordless sync pulse
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      txSfOut_r <= 1'b0;
      rxSfOut_r <= 1'b0;
    end else begin
      txSfOut_r <= ctrlSeven_r ? coreCordlessMsgOk : coreTxSfMark;
      rxSfOut_r <= coreRxSfLevel;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wake_r <= 1'b0;
    end else if (corePoweredUp) begin
      wake_r <= 1'b0;
    end else if (wakeSet) begin
      wake_r <= 1'b1;
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_chan;
    assignerMode |-> chanNumber == {p17, p19, p7};
  endproperty
  a_chan: assert property (p_chan) else $error("channel number mismatch");

  property p_cfg;
    moPin |-> nonAuto == (p17 && !p19);
  endproperty
  a_cfg: assert property (p_cfg) else $error("strap configuration mismatch");

  property p_io1;
    (~mwPin & nonAuto) |-> generalPinOneOe == ~ctrlFive_r[`LTS_BIT_IO1_DIR];
  endproperty
  a_io1: assert property (p_io1) else $error("general pin direction wrong");

  property p_ps1;
    (~mwPin & (cfgNt1 | cfgNtrr)) |-> ps1Bit == gpPin && !generalPinOneOe;
  endproperty
  a_ps1: assert property (p_ps1) else $error("ps1 not from status pin");

  property p_pll;
    pll1Disable |-> cfgLtrr && gpPin;
  endproperty
  a_pll: assert property (p_pll) else $error("pll disabled outside LTRR");

  property p_febe;
    febeReportEn |-> autoMode && p22;
  endproperty
  a_febe: assert property (p_febe) else $error("febe report wrongly enabled");

  property p_sfdir;
    nonAuto & (ntMode | sfDir) |-> txSuperframeOe;
  endproperty
  a_sfdir: assert property (p_sfdir) else $error("tx superframe not driven");

  property p_cordless;
    (ctrlSeven_r & coreCordlessMsgOk) |=> txSuperframeOut;
  endproperty
  a_cordless: assert property (p_cordless) else $error("cordless pulse missing");

  property p_rxsf;
    rxSuperframeOe |-> ctrlFour_r && (assignerMode || cfgNtte);
  endproperty
  a_rxsf: assert property (p_rxsf) else $error("rx superframe driven wrongly");

  property p_wake;
    (wakeSet & ~corePoweredUp) ##1 !corePoweredUp |-> lineWakeOe;
  endproperty
  a_wake: assert property (p_wake) else $error("wake pin not pulled");

  property p_release;
    corePoweredUp |=> !lineWakeOe;
  endproperty
  a_release: assert property (p_release) else $error("wake pin not released");

  property p_clear;
    !clearN |=> ctrlTwo_r == `LTS_RST_CTRL_TWO && irqStat_r == '0;
  endproperty
  a_clear: assert property (p_clear) else $error("clear did not reset");

  property p_fsa;
    (~mwPin & ~moPin) |-> !frameSyncAOe;
  endproperty
  a_fsa: assert property (p_fsa) else $error("frame sync a driven in assigner mode");

  property p_pin7;
    (~mwPin & moPin & p17 & ~p19) |-> pin7Oe && !lineTestSelB;
  endproperty
  a_pin7: assert property (p_pin7) else $error("pin 7 strobe not driven");

endmodule

// ---- rtl/lts_sync2.sv ----
/*
  Two flip-flop synchroniser for a group of pin levels.
  Assumes the inputs are quasi-static levels from outside the clock domain.
*/
module lts_sync2 #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // levels
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] meta_r;

  // first stage is read only by the second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_r  <= '0;
      syncOut <= '0;
    end else begin
      meta_r  <= asyncIn;
      syncOut <= meta_r;
    end
  end
endmodule
